// ==== shared/emcft_pkg.sv ====
// package: register map, field layout, types for the memory config/timing block
package emcft_pkg;
    localparam logic [7:0]  EMCFT_SDRAM_CONFIG_OFFSET  = 8'h08;
    localparam logic [7:0]  EMCFT_ASYNC_CS2_OFFSET     = 8'h10;
    localparam logic [7:0]  EMCFT_ASYNC_CS3_OFFSET     = 8'h14;
    localparam logic [7:0]  EMCFT_STATUS_OFFSET        = 8'h20;

    localparam logic [31:0] EMCFT_SDRAM_CONFIG_RESET   = 32'h0000_0600;
    localparam logic [31:0] EMCFT_ASYNC_CONFIG_RESET   = 32'h3fff_fffc;
    localparam logic [31:0] EMCFT_SDRAM_WRITE_MASK     = 32'h8000_4e77;

    localparam int SELF_REFRESH_BIT    = 31;
    localparam int NARROW_BUS_BIT      = 14;
    localparam int CAS_LAT_LSB         = 9;
    localparam int LAT_UNLOCK_BIT      = 8;
    localparam int BANK_COUNT_LSB      = 4;
    localparam int PAGE_SIZE_LSB       = 0;

    localparam int SEL_STROBE_BIT      = 31;
    localparam int EXT_WAIT_BIT        = 30;
    localparam int W_SETUP_LSB         = 26;
    localparam int W_STROBE_LSB        = 20;
    localparam int W_HOLD_LSB          = 17;
    localparam int R_SETUP_LSB         = 13;
    localparam int R_STROBE_LSB        = 7;
    localparam int R_HOLD_LSB          = 4;
    localparam int TURNAROUND_LSB      = 2;
    localparam int BUS_WIDTH_LSB       = 0;

    localparam logic [2:0] CAS_LATENCY_THREE = 3'h3;
    localparam logic [1:0] ASYNC_WIDTH_16    = 2'h1;
    localparam logic [1:0] TURNAROUND_MAX    = 2'h3;
    localparam logic [11:0] PAGE_WORDS_BASE  = 12'h100;

    typedef enum logic [4:0] {
        EMCFT_IDLE   = 5'b0_0001,
        EMCFT_SETUP  = 5'b0_0010,
        EMCFT_STROBE = 5'b0_0100,
        EMCFT_HOLD   = 5'b0_1000,
        EMCFT_TURN   = 5'b1_0000
    } emcft_state_e;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        cs_three;
        logic [15:0] wdata;
    } emcft_req_s;

    typedef struct packed {
        logic       sel_strobe;
        logic [5:0] setup;
        logic [5:0] strobe;
        logic [5:0] hold;
        logic [1:0] turn;
        logic       wide;
    } emcft_timing_s;
endpackage

// ==== hdl/emcft_top.sv ====
// config decode and async strobe timing for the external memory interface
`timescale 1ns/1ps
`default_nettype none
module emcft_top
    import emcft_pkg::*;
#(
    parameter int DATA_WIDTH = 16
) (
    input  wire logic              mclk,
    input  wire logic              reset,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic [3:0]        reg_byte_en,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic      [31:0]       reg_rdata,
    input  wire emcft_req_s        acc_req,
    output logic                   acc_busy,
    output logic                   acc_done,
    output logic [DATA_WIDTH-1:0]  acc_rdata,
    output logic                   self_refresh_active,
    output logic                   sdram_init_start,
    output logic                   sdram_narrow_bus,
    output logic [1:0]             cas_latency_cycles,
    output logic [3:0]             bank_count,
    output logic [11:0]            page_words,
    output logic                   chip_select_two_n,
    output logic                   chip_select_three_n,
    output logic                   read_strobe_n,
    output logic                   write_strobe_n,
    output logic                   async_wide_bus,
    input  wire logic [DATA_WIDTH-1:0] memory_data_in,
    output logic [DATA_WIDTH-1:0]  memory_data_out,
    output logic                   memory_data_oe_n
);
    if (DATA_WIDTH != 16) begin : g_width_check
        $error("emcft_top: DATA_WIDTH must be 16");
    end

    // per-byte merge of a register write
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // async config word into phase counts; tight phase sizing is up to software
    function automatic emcft_timing_s timing_of(input logic [31:0] cfg,
                                                input logic        wr);
        emcft_timing_s t;
        t.sel_strobe = cfg[SEL_STROBE_BIT];
        t.turn       = cfg[TURNAROUND_LSB +: 2];
        t.wide       = (cfg[BUS_WIDTH_LSB +: 2] == ASYNC_WIDTH_16);
        if (wr) begin
            t.setup  = {2'h0, cfg[W_SETUP_LSB +: 4]};
            t.strobe = cfg[W_STROBE_LSB +: 6];
            t.hold   = {3'h0, cfg[W_HOLD_LSB +: 3]};
        end else begin
            t.setup  = {2'h0, cfg[R_SETUP_LSB +: 4]};
            t.strobe = cfg[R_STROBE_LSB +: 6];
            t.hold   = {3'h0, cfg[R_HOLD_LSB +: 3]};
        end
        return t;
    endfunction

    logic [31:0]   sdram_config;
    logic [31:0]   async_cs2_config;
    logic [31:0]   async_cs3_config;
    logic [31:0]   next_sdram_config;
    logic [31:0]   next_async_cs2_config;
    logic [31:0]   next_async_cs3_config;
    logic [31:0]   next_reg_rdata;
    logic [31:0]   sdram_merged;
    logic [2:0]    next_cas_code;

    emcft_state_e  state;
    emcft_state_e  next_state;
    emcft_timing_s timing;
    logic [5:0]    phase_count;
    logic [5:0]    next_phase_count;
    logic          is_write;
    logic          use_cs_three;
    logic [DATA_WIDTH-1:0] data_sync_a;
    logic [DATA_WIDTH-1:0] data_sync_b;

    wire hit_sdram  = (reg_addr == EMCFT_SDRAM_CONFIG_OFFSET);
    wire hit_cs2    = (reg_addr == EMCFT_ASYNC_CS2_OFFSET);
    wire hit_cs3    = (reg_addr == EMCFT_ASYNC_CS3_OFFSET);
    wire hit_status = (reg_addr == EMCFT_STATUS_OFFSET);
    wire wr_sdram   = reg_write && hit_sdram;
    wire wr_cs2     = reg_write && hit_cs2;
    wire wr_cs3     = reg_write && hit_cs3;
    wire phase_last = (phase_count == 6'h00);
    wire start_acc  = acc_req.valid && (state == EMCFT_IDLE);
    wire unlock_cl  = reg_wdata[LAT_UNLOCK_BIT] && reg_byte_en[1];
    wire [31:0] status_word = {27'h0, state};

    // register writes
    always_comb begin
        sdram_merged = merge_bytes(sdram_config, reg_wdata, reg_byte_en);
        next_cas_code = sdram_config[CAS_LAT_LSB +: 3];
        if (unlock_cl) begin
            next_cas_code = sdram_merged[CAS_LAT_LSB +: 3];
        end
        next_sdram_config = sdram_config;
        if (wr_sdram) begin
            next_sdram_config = sdram_merged & EMCFT_SDRAM_WRITE_MASK;
            next_sdram_config[CAS_LAT_LSB +: 3] = next_cas_code;
            next_sdram_config[LAT_UNLOCK_BIT] = 1'b0;
        end
        next_async_cs2_config = async_cs2_config;
        if (wr_cs2) begin
            next_async_cs2_config = merge_bytes(async_cs2_config, reg_wdata, reg_byte_en);
        end
        next_async_cs3_config = async_cs3_config;
        if (wr_cs3) begin
            next_async_cs3_config = merge_bytes(async_cs3_config, reg_wdata, reg_byte_en);
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        next_reg_rdata = 32'h0000_0000;
        if (!reg_read) begin
            next_reg_rdata = 32'h0000_0000;
        end else if (hit_sdram) begin
            next_reg_rdata = sdram_config;
        end else if (hit_cs2) begin
            next_reg_rdata = async_cs2_config;
        end else if (hit_cs3) begin
            next_reg_rdata = async_cs3_config;
        end else if (hit_status) begin
            next_reg_rdata = status_word;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            sdram_config     <= EMCFT_SDRAM_CONFIG_RESET;
            async_cs2_config <= EMCFT_ASYNC_CONFIG_RESET;
            async_cs3_config <= EMCFT_ASYNC_CONFIG_RESET;
            reg_rdata        <= 32'h0000_0000;
        end else begin
            sdram_config     <= next_sdram_config;
            async_cs2_config <= next_async_cs2_config;
            async_cs3_config <= next_async_cs3_config;
            reg_rdata        <= next_reg_rdata;
        end
    end

    // sdram decode outputs, registered
    always_ff @(posedge mclk) begin
        if (reset) begin
            self_refresh_active <= 1'b0;
            sdram_init_start    <= 1'b0;
            sdram_narrow_bus    <= 1'b0;
            cas_latency_cycles  <= 2'h3;
            bank_count          <= 4'h1;
            page_words          <= PAGE_WORDS_BASE;
        end else begin
            self_refresh_active <= sdram_config[SELF_REFRESH_BIT];
            // a top-byte-only write leaves the init sequence alone
            sdram_init_start    <= wr_sdram && (|reg_byte_en[2:0]);
            sdram_narrow_bus    <= sdram_config[NARROW_BUS_BIT];
            cas_latency_cycles  <= (sdram_config[CAS_LAT_LSB +: 3] == CAS_LATENCY_THREE)
                                   ? 2'h3 : 2'h2;
            bank_count          <= 4'h1 << sdram_config[BANK_COUNT_LSB +: 2];
            page_words          <= PAGE_WORDS_BASE << sdram_config[PAGE_SIZE_LSB +: 2];
        end
    end

    // async sequencer: setup, strobe, hold, then turnaround with selects high
    always_comb begin
        next_state       = state;
        next_phase_count = phase_count;
        case (state)
            EMCFT_IDLE: begin
                if (start_acc) begin
                    next_state = EMCFT_SETUP;
                    next_phase_count = timing_of(acc_req.cs_three ? async_cs3_config
                                                 : async_cs2_config, acc_req.write).setup;
                end
            end
            EMCFT_SETUP: begin
                next_phase_count = phase_count - 6'h01;
                if (phase_last) begin
                    next_state = EMCFT_STROBE;
                    next_phase_count = timing.strobe;
                end
            end
            EMCFT_STROBE: begin
                next_phase_count = phase_count - 6'h01;
                if (phase_last) begin
                    next_state = EMCFT_HOLD;
                    next_phase_count = timing.hold;
                end
            end
            EMCFT_HOLD: begin
                next_phase_count = phase_count - 6'h01;
                if (phase_last) begin
                    next_state = EMCFT_TURN;
                    next_phase_count = {4'h0, timing.turn};
                end
            end
            EMCFT_TURN: begin
                next_phase_count = phase_count - 6'h01;
                if (phase_last) begin
                    next_state = EMCFT_IDLE;
                    next_phase_count = 6'h00;
                end
            end
            default: begin
                next_state = EMCFT_IDLE;
                next_phase_count = 6'h00;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state        <= EMCFT_IDLE;
            phase_count  <= 6'h00;
            timing       <= '0;
            is_write     <= 1'b0;
            use_cs_three <= 1'b0;
        end else begin
            state       <= next_state;
            phase_count <= next_phase_count;
            if (start_acc) begin
                // config snapshot: a rewrite mid-access cannot reshape it
                timing       <= timing_of(acc_req.cs_three ? async_cs3_config
                                          : async_cs2_config, acc_req.write);
                is_write     <= acc_req.write;
                use_cs_three <= acc_req.cs_three;
            end
        end
    end

    // pin data is asynchronous to mclk; reads see it two cycles late
    always_ff @(posedge mclk) begin
        if (reset) begin
            data_sync_a <= '0;
            data_sync_b <= '0;
        end else begin
            data_sync_a <= memory_data_in;
            data_sync_b <= data_sync_a;
        end
    end

    wire in_access  = (state == EMCFT_SETUP) || (state == EMCFT_STROBE) ||
                      (state == EMCFT_HOLD);
    wire in_strobe  = (state == EMCFT_STROBE);
    // select-strobe mode narrows the select to the strobe phase
    wire cs_active  = timing.sel_strobe ? in_strobe : in_access;
    wire next_cs2_n = !(cs_active && !use_cs_three);
    wire next_cs3_n = !(cs_active && use_cs_three);
    wire next_rd_n  = !(in_strobe && !is_write);
    wire next_wr_n  = !(in_strobe && is_write);
    wire next_oe_n  = !(in_access && is_write);
    wire read_grab  = in_strobe && phase_last && !is_write;
    wire next_done  = (state == EMCFT_HOLD) && phase_last;

    always_ff @(posedge mclk) begin
        if (reset) begin
            chip_select_two_n   <= 1'b1;
            chip_select_three_n <= 1'b1;
            read_strobe_n       <= 1'b1;
            write_strobe_n      <= 1'b1;
            memory_data_oe_n    <= 1'b1;
            memory_data_out     <= '0;
            async_wide_bus      <= 1'b0;
            acc_rdata           <= '0;
            acc_done            <= 1'b0;
        end else begin
            chip_select_two_n   <= next_cs2_n;
            chip_select_three_n <= next_cs3_n;
            read_strobe_n       <= next_rd_n;
            write_strobe_n      <= next_wr_n;
            memory_data_oe_n    <= next_oe_n;
            async_wide_bus      <= timing.wide;
            acc_done            <= next_done;
            if (start_acc) begin
                memory_data_out <= acc_req.wdata;
            end
            if (read_grab) begin
                acc_rdata <= timing.wide ? data_sync_b
                             : {{(DATA_WIDTH-8){1'b0}}, data_sync_b[7:0]};
            end
        end
    end

    assign acc_busy = (state != EMCFT_IDLE);
endmodule
`default_nettype wire

// ==== tb/emcft_sva.sv ====
// checker: config decode and strobe relations seen at the top ports
`timescale 1ns/1ps
`default_nettype none
module emcft_sva
    import emcft_pkg::*;
(
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [3:0]  reg_byte_en,
    input wire logic        reg_write,
    input wire logic        acc_done,
    input wire logic        self_refresh_active,
    input wire logic        sdram_init_start,
    input wire logic        sdram_narrow_bus,
    input wire logic [1:0]  cas_latency_cycles,
    input wire logic [3:0]  bank_count,
    input wire logic [11:0] page_words,
    input wire logic        chip_select_two_n,
    input wire logic        chip_select_three_n,
    input wire logic        read_strobe_n,
    input wire logic        write_strobe_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    wire cfg_wr = reg_write && (reg_addr == EMCFT_SDRAM_CONFIG_OFFSET);
    wire low_wr = cfg_wr && (|reg_byte_en[2:0]);
    wire unlock = cfg_wr && reg_byte_en[1] && reg_wdata[8];

    a_refresh_follows: assert property (cfg_wr && reg_byte_en[3] |->
        ##2 self_refresh_active == $past(reg_wdata[31], 2)) else $error("self refresh mismatch");
    a_narrow_follows: assert property (cfg_wr && reg_byte_en[1] |->
        ##2 sdram_narrow_bus == $past(reg_wdata[14], 2)) else $error("narrow bus mismatch");
    a_latency_three: assert property (unlock && reg_wdata[11:9] == 3'h3 |->
        ##2 cas_latency_cycles == 2'h3) else $error("latency not three");
    a_latency_locked: assert property (cfg_wr && !unlock |->
        ##2 $stable(cas_latency_cycles)) else $error("latency changed while locked");
    a_banks_four: assert property (cfg_wr && reg_byte_en[0] && reg_wdata[6:4] == 3'h2 |->
        ##2 bank_count == 4'h4) else $error("bank count not four");
    a_page_base: assert property (cfg_wr && reg_byte_en[0] && reg_wdata[2:0] == 3'h0 |->
        ##2 page_words == 12'h100) else $error("page size not base");
    a_init_pulse: assert property (low_wr |=> sdram_init_start)
        else $error("init start missing");
    a_init_quiet: assert property (!low_wr |=> !sdram_init_start)
        else $error("init start without low byte write");
    a_strobe_selected: assert property (!read_strobe_n || !write_strobe_n |->
        !(chip_select_two_n && chip_select_three_n)) else $error("strobe without select");
    a_done_single: assert property (acc_done |=> !acc_done)
        else $error("done longer than one cycle");

    c_cfg_write: cover property (low_wr);
    c_read_strobe: cover property (!read_strobe_n);
    c_access_done: cover property (acc_done);
endmodule
bind emcft_top emcft_sva chk_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_byte_en(reg_byte_en), .reg_write(reg_write),
    .acc_done(acc_done), .self_refresh_active(self_refresh_active),
    .sdram_init_start(sdram_init_start), .sdram_narrow_bus(sdram_narrow_bus),
    .cas_latency_cycles(cas_latency_cycles), .bank_count(bank_count),
    .page_words(page_words), .chip_select_two_n(chip_select_two_n),
    .chip_select_three_n(chip_select_three_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n));
`default_nettype wire

// ==== tb/emcft_mem_model.sv ====
// far-side model: one-word asynchronous memory on one chip select
`timescale 1ns/1ps
`default_nettype none
module emcft_mem_model (
    input  wire logic        mclk,
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [15:0] wdata,
    output logic      [15:0] rdata,
    output logic      [15:0] stored
);
    initial begin
        rdata = 16'h0000;
        stored = 16'h0000;
    end
    always @(posedge mclk) begin
        if (!cs_n && !wr_n) begin
            stored <= wdata;
        end
        // released bus toggles so a stale value never looks valid
        rdata <= (!cs_n && !rd_n) ? stored : ~rdata;
    end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the memory config and strobe timing block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import emcft_pkg::*;
    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  be;
        logic        refresh;
        logic        narrow;
        logic [1:0]  cas;
        logic [3:0]  banks;
        logic [11:0] words;
    } emcft_row_s;
    localparam emcft_row_s ROWS [5] = '{
        '{32'h0000_4720, 4'hf, 1'b0, 1'b1, 2'h3, 4'h4, 12'h100},
        '{32'h8000_0000, 4'h8, 1'b1, 1'b1, 2'h3, 4'h4, 12'h100}, // top byte only
        '{32'h0000_0000, 4'h8, 1'b0, 1'b1, 2'h3, 4'h4, 12'h100},
        '{32'h0000_0400, 4'hf, 1'b0, 1'b0, 2'h3, 4'h1, 12'h100},
        '{32'h0000_0511, 4'hf, 1'b0, 1'b0, 2'h2, 4'h2, 12'h200}};
    // strobe covers access, hold covers data hold and release
    // write phases meet select-high and cycle time, plus margin
    localparam int WS = 2, WT = 6, WH = 1, RS = 1, RT = 11, RH = 3, TN = 3;
    localparam logic [31:0] ACFG = {2'h2, 4'(WS), 6'(WT), 3'(WH), 4'(RS), 6'(RT), 3'(RH),
                                    2'(TN), 2'h1};
    // same timing, plain select and 8-bit bus
    localparam logic [31:0] ACFG_N = {1'b0, ACFG[30:2], 2'h0};
    logic mclk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000, rd;
    logic [3:0] reg_byte_en = 4'h0;
    emcft_req_s acc_req = '0;
    logic [31:0] reg_rdata;
    logic acc_busy, acc_done, self_refresh_active, sdram_init_start, sdram_narrow_bus;
    logic [1:0] cas_latency_cycles;
    logic [3:0] bank_count;
    logic [11:0] page_words;
    logic cs2_n, cs3_n, rd_n, wr_n, async_wide_bus, memory_data_oe_n;
    logic [15:0] acc_rdata, memory_data_in, memory_data_out, stored;
    int fails = 0, num_checks = 0, cycles = 0, nb, ns, nc, nd, n3, no;

    emcft_top #(.DATA_WIDTH(16)) dut_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_byte_en(reg_byte_en), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .acc_req(acc_req), .acc_busy(acc_busy),
        .acc_done(acc_done), .acc_rdata(acc_rdata), .self_refresh_active(self_refresh_active),
        .sdram_init_start(sdram_init_start), .sdram_narrow_bus(sdram_narrow_bus),
        .cas_latency_cycles(cas_latency_cycles), .bank_count(bank_count),
        .page_words(page_words), .chip_select_two_n(cs2_n), .chip_select_three_n(cs3_n),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .async_wide_bus(async_wide_bus),
        .memory_data_in(memory_data_in), .memory_data_out(memory_data_out),
        .memory_data_oe_n(memory_data_oe_n));
    emcft_mem_model mem_u (.mclk(mclk), .cs_n(cs2_n), .rd_n(rd_n), .wr_n(wr_n),
        .wdata(memory_data_out), .rdata(memory_data_in), .stored(stored));

    always #5 mclk = ~mclk;
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // generous ceiling: whole sequence needs a few hundred cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            complete_run();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge mclk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        reg_byte_en <= be;
        @(posedge mclk);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic reg_rd(input logic [7:0] a);
        @(posedge mclk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1 rd = reg_rdata;
    endtask
    // a 40-cycle window covers the longest programmed access
    task automatic access(input logic wr, input logic c3, input logic [15:0] d);
        nb = 0; ns = 0; nc = 0; nd = 0; n3 = 0; no = 0;
        @(posedge mclk);
        acc_req <= '{valid: 1'b1, write: wr, cs_three: c3, wdata: d};
        @(posedge mclk);
        acc_req.valid <= 1'b0;
        repeat (40) begin
            #1;
            nb += int'(acc_busy);
            ns += int'(!rd_n || !wr_n);
            nc += int'(!cs2_n);
            nd += int'(acc_done);
            n3 += int'(!cs3_n);
            no += int'(!memory_data_oe_n);
            @(posedge mclk);
        end
    endtask

    initial begin
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        #1;
        check("reset latency", 32'(2'h3), 32'(cas_latency_cycles));
        check("reset banks", 32'(4'h1), 32'(bank_count));
        reg_rd(EMCFT_SDRAM_CONFIG_OFFSET);
        check("sdram config reset", 32'h0000_0600, rd);
        reg_rd(EMCFT_ASYNC_CS3_OFFSET);
        check("cs3 config reset", 32'h3fff_fffc, rd);
        for (int i = 0; i < 5; i++) begin
            reg_wr(EMCFT_SDRAM_CONFIG_OFFSET, ROWS[i].data, ROWS[i].be);
            check("init start", 32'(|ROWS[i].be[2:0]), 32'(sdram_init_start));
            repeat (2) @(posedge mclk);
            #1;
            check("self refresh", 32'(ROWS[i].refresh), 32'(self_refresh_active));
            check("narrow bus", 32'(ROWS[i].narrow), 32'(sdram_narrow_bus));
            check("cas latency", 32'(ROWS[i].cas), 32'(cas_latency_cycles));
            check("bank count", 32'(ROWS[i].banks), 32'(bank_count));
            check("page words", 32'(ROWS[i].words), 32'(page_words));
        end
        reg_wr(8'h3c, 32'hffff_ffff, 4'hf);
        reg_rd(8'h3c);
        check("unmapped read", 32'h0000_0000, rd);
        reg_rd(EMCFT_STATUS_OFFSET);
        check("status idle", 32'(EMCFT_IDLE), rd);
        reg_rd(EMCFT_SDRAM_CONFIG_OFFSET);
        check("sdram config readback", 32'h0000_0411, rd);
        reg_wr(EMCFT_ASYNC_CS2_OFFSET, ACFG, 4'hf);
        reg_rd(EMCFT_ASYNC_CS2_OFFSET);
        check("cs2 config readback", ACFG, rd);
        access(1'b1, 1'b0, 16'hc35a);
        check("write busy", 32'(WS + WT + WH + TN + 4), 32'(nb));
        check("write strobe", 32'(WT + 1), 32'(ns));
        check("write select", 32'(WT + 1), 32'(nc));
        check("write done", 32'h1, 32'(nd));
        check("stored word", 32'h0000_c35a, 32'(stored));
        check("write oe", 32'(WS + WT + WH + 3), 32'(no));
        check("write other select", 32'h0, 32'(n3));
        access(1'b0, 1'b0, 16'h0000);
        check("read busy", 32'(RS + RT + RH + TN + 4), 32'(nb));
        check("read strobe", 32'(RT + 1), 32'(ns));
        check("read select", 32'(RT + 1), 32'(nc));
        check("read data", 32'h0000_c35a, 32'(acc_rdata));
        check("wide bus", 32'h1, 32'(async_wide_bus));
        check("read oe", 32'h0, 32'(no));
        reg_wr(EMCFT_ASYNC_CS2_OFFSET, ACFG_N, 4'hf);
        access(1'b0, 1'b0, 16'h0000);
        check("plain read select", 32'(RS + RT + RH + 3), 32'(nc));
        check("plain read strobe", 32'(RT + 1), 32'(ns));
        check("narrow read data", 32'h0000_005a, 32'(acc_rdata));
        check("narrow bus", 32'h0, 32'(async_wide_bus));
        reg_wr(EMCFT_ASYNC_CS3_OFFSET, ACFG, 4'hf);
        access(1'b1, 1'b1, 16'h1234);
        check("cs3 write select", 32'(WT + 1), 32'(n3));
        check("cs3 leaves cs2", 32'h0, 32'(nc));
        check("cs3 write oe", 32'(WS + WT + WH + 3), 32'(no));
        check("cs2 word kept", 32'h0000_c35a, 32'(stored));
        complete_run();
    end
endmodule
`default_nettype wire
